// *** design/its_target.sv ***
// Functional notes
// RQ1 - Pending flag is up while the target waits on software.
// RQ2 - Not-holding flag reads 0 while SCL is held low, 1 otherwise.
// RQ3 - Selected flag sets on an address match and stays while addressed.
// RQ4 - A selected-to-unselected change latches a flag cleared by writing 1.
// RQ5 - The deselect flag is sticky and separate from the live selected bit.
// RQ6 - Four 7-bit address slots, each with its own disable.
// RQ7 - In mask mode the qualifier masks bits compared against slot 0.
// RQ8 - In extend mode slot 0 matches the range from slot 0 to the qualifier.
// RQ9 - The address byte after every start or repeated start is checked.
// RQ10 - The matched byte is readable, address high and direction in bit 0.
// RQ11 - Releasing a stretch first waits one clock-divider period.
// RQ12 - Software sets the divider above the bus data setup time.
// RQ13 - Matching and bus answers happen only while the target is enabled.
// RQ14 - Matched addresses are acknowledged, others left released as NACK.
module its_target #(
  parameter int DIV_W = 16,
  parameter int FIFO_DEPTH = 32
) (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // configuration
  input wire its_pkg::its_cfg_t cfg,
  input wire logic [DIV_W-1:0] bus_clock_divider,
  // software handshake
  input wire logic sw_continue,
  input wire logic [its_pkg::ITS_BYTE_W-1:0] tx_byte,
  input wire logic deselect_clear,
  // status
  output its_pkg::its_stat_t stat,
  output logic match_event,
  // received bytes
  output logic [its_pkg::ITS_BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import its_pkg::*;

  // refuse widths the down counter cannot serve
  if (DIV_W < 1 || DIV_W > 32 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("its_target: unsupported divider width or fifo depth");
  end

  //////////////////////////////////////////////////////////////////////////
  // address matching

  // RQ6 four slots
  function automatic logic addr_hit(input logic [ITS_ADDR_W-1:0] a,
                                    input its_cfg_t c);
    logic h0;
    logic hit;
    logic [ITS_ADDR_W-1:0] a0;
    a0 = c.target_address_field[0];
    // RQ8 range match
    if (c.qual_extend) begin
      h0 = (a >= a0) && (a <= c.address0_qualifier);
    // RQ7 masked compare
    end else begin
      h0 = ((a ^ a0) & ~c.address0_qualifier) == '0;
    end
    hit = h0 && !c.address_slot_disable[0];
    for (int i = 1; i < ITS_SLOTS; i++) begin
      hit = hit || (!c.address_slot_disable[i] &&
                    a == c.target_address_field[i]);
    end
    return hit;
  endfunction : addr_hit

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;

  // bit 0 feeds only bit 1; bits 1 and 2 are safe to read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_sync_r <= ITS_SYNC_RST;
      sda_sync_r <= ITS_SYNC_RST;
    end else if (ce) begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  assign scl_s = scl_sync_r[1];
  assign scl_p = scl_sync_r[2];
  assign sda_s = sda_sync_r[1];
  assign sda_p = sda_sync_r[2];

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_c = scl_s && scl_p && sda_p && !sda_s;
  assign stop_c = scl_s && scl_p && !sda_p && sda_s;

  //////////////////////////////////////////////////////////////////////////
  // byte engine

  its_state_t st_r;
  its_state_t resume_r;
  logic [3:0] bit_cnt_r;
  logic [ITS_BYTE_W-1:0] shift_r;
  logic dir_rd_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic match_event_r;
  logic fifo_in_ready;
  logic take;
  logic hit;

  // RQ9 address byte complete
  assign take = st_r == ITS_ADDR && scl_fall && bit_cnt_r == ITS_CNT_BYTE &&
                cfg.enable && !stop_c && !start_c;
  assign hit = addr_hit(shift_r[ITS_BYTE_W-1:1], cfg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ITS_IDLE;
      resume_r <= ITS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      dir_rd_r <= 1'b0;
      div_cnt_r <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      match_event_r <= 1'b0;
    end else if (ce) begin
      match_event_r <= 1'b0;
      // RQ13 disabled target stays off the bus
      if (!cfg.enable || stop_c) begin
        st_r <= ITS_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      // RQ9 start or repeated start
      end else if (start_c) begin
        st_r <= ITS_ADDR;
        bit_cnt_r <= 4'h0;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (st_r)
          ITS_IDLE: begin
          end
          ITS_ADDR: begin
            if (scl_rise && bit_cnt_r != ITS_CNT_BYTE) begin
              shift_r <= {shift_r[ITS_BYTE_W-2:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (take) begin
              // RQ14 ack or nack
              if (hit) begin
                sda_oe_r <= 1'b1;
                st_r <= ITS_AACK;
                match_event_r <= 1'b1;
                dir_rd_r <= shift_r[0];
              end else begin
                st_r <= ITS_IDLE;
              end
            end
          end
          ITS_AACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              scl_oe_r <= 1'b1;
              st_r <= ITS_STRETCH;
            end
          end
          ITS_STRETCH: begin
            if (sw_continue) begin
              bit_cnt_r <= 4'h0;
              div_cnt_r <= bus_clock_divider;
              st_r <= ITS_SETUP;
              if (dir_rd_r) begin
                shift_r <= tx_byte;
                sda_oe_r <= !tx_byte[ITS_BYTE_W-1];
                resume_r <= ITS_TX;
              end else begin
                resume_r <= ITS_RX;
              end
            end
          end
          // RQ11 one divider period before release
          ITS_SETUP: begin
            if (div_cnt_r == '0) begin
              scl_oe_r <= 1'b0;
              st_r <= resume_r;
            end else begin
              div_cnt_r <= div_cnt_r - 1'b1;
            end
          end
          ITS_RX: begin
            if (scl_rise && bit_cnt_r != ITS_CNT_BYTE) begin
              shift_r <= {shift_r[ITS_BYTE_W-2:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == ITS_CNT_BYTE) begin
              scl_oe_r <= 1'b1;
              st_r <= ITS_HOLD;
            end
          end
          // full fifo keeps scl low instead of dropping data
          ITS_HOLD: begin
            if (fifo_in_ready) begin
              sda_oe_r <= 1'b1;
              div_cnt_r <= bus_clock_divider;
              resume_r <= ITS_RXACK;
              st_r <= ITS_SETUP;
            end
          end
          ITS_RXACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              st_r <= ITS_RX;
            end
          end
          ITS_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == ITS_CNT_LAST_TX) begin
                sda_oe_r <= 1'b0;
                bit_cnt_r <= 4'h0;
                st_r <= ITS_TXACK;
              end else begin
                shift_r <= {shift_r[ITS_BYTE_W-2:0], 1'b0};
                sda_oe_r <= !shift_r[ITS_BYTE_W-2];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          ITS_TXACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_r <= ITS_IDLE;
              end else begin
                bit_cnt_r <= ITS_CNT_BYTE;
              end
            end else if (scl_fall && bit_cnt_r == ITS_CNT_BYTE) begin
              scl_oe_r <= 1'b1;
              st_r <= ITS_STRETCH;
            end
          end
          default: begin
            st_r <= ITS_IDLE;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive fifo

  logic fifo_in_valid;

  assign fifo_in_valid = st_r == ITS_HOLD && cfg.enable && !stop_c &&
                         !start_c;

  its_fifo #(
    .WIDTH(ITS_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) its_fifo_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(shift_r),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // status

  its_stat_t stat_r;
  logic sel_nxt;
  logic held;

  assign held = st_r == ITS_STRETCH || st_r == ITS_HOLD;

  // RQ3 set on match, drop on stop, miss or disable
  always_comb begin
    if (take && hit) begin
      sel_nxt = 1'b1;
    end else if (stop_c || !cfg.enable || (take && !hit)) begin
      sel_nxt = 1'b0;
    end else begin
      sel_nxt = stat_r.target_selected_flag;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_r <= ITS_STAT_RST;
    end else if (ce) begin
      // RQ1 waiting on software
      stat_r.software_wait_flag <= held;
      // RQ2 inverted hold indication
      stat_r.not_holding_scl_flag <= !scl_oe_r;
      stat_r.target_selected_flag <= sel_nxt;
      // RQ4 RQ5 sticky, set wins over clear
      stat_r.deselect_event_flag <=
        (stat_r.target_selected_flag && !sel_nxt) ||
        (stat_r.deselect_event_flag && !deselect_clear);
      // RQ10 address high, direction low
      if (take && hit) begin
        stat_r.matched_byte <= shift_r;
      end
    end
  end

  assign stat = stat_r;
  assign match_event = match_event_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  // open drain: the driven level is always low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_release_req;
    ce && cfg.enable && !start_c && !stop_c && st_r == ITS_STRETCH &&
      sw_continue;
  endsequence

  sequence s_setup_held;
    st_r == ITS_SETUP && scl_oe_r;
  endsequence

  property p_pending;
    ce |=> stat_r.software_wait_flag == $past(held);
  endproperty
  a_pending: assert property (p_pending) // RQ1
    else $error("pending flag does not follow the wait state");

  property p_not_holding;
    ce |=> stat_r.not_holding_scl_flag == !$past(scl_oe_r);
  endproperty
  a_not_holding: assert property (p_not_holding) // RQ2
    else $error("not-holding flag disagrees with scl hold");

  property p_selected;
    match_event_r |-> stat_r.target_selected_flag &&
      stat_r.matched_byte[0] == dir_rd_r;
  endproperty
  a_selected: assert property (p_selected) // RQ3
    else $error("match without selected flag or direction");

  property p_deselect_set;
    $fell(stat_r.target_selected_flag) |-> stat_r.deselect_event_flag;
  endproperty
  a_deselect_set: assert property (p_deselect_set) // RQ4
    else $error("deselect flag not latched");

  property p_deselect_sticky;
    (stat_r.deselect_event_flag && !(ce && deselect_clear)) |=>
      stat_r.deselect_event_flag;
  endproperty
  a_deselect_sticky: assert property (p_deselect_sticky) // RQ5
    else $error("deselect flag lost without a clear");

  property p_setup_gap;
    s_release_req |=> s_setup_held ##1 scl_oe_r;
  endproperty
  a_setup_gap: assert property (p_setup_gap) // RQ11
    else $error("scl released without a divider period");

  property p_disabled;
    (ce && !cfg.enable) |=> st_r == ITS_IDLE && !scl_oe_r && !sda_oe_r;
  endproperty
  a_disabled: assert property (p_disabled) // RQ13
    else $error("disabled target still active on the bus");

  property p_nack;
    (ce && take && !hit) |=> !sda_oe_r && st_r == ITS_IDLE;
  endproperty
  a_nack: assert property (p_nack) // RQ14
    else $error("unmatched address was acknowledged");

  property p_ack;
    (ce && take && hit) |=> sda_oe_r && match_event_r;
  endproperty
  a_ack: assert property (p_ack) // RQ14
    else $error("matched address not acknowledged");

endmodule : its_target

// *** design/its_pkg.sv ***
package its_pkg;

  localparam int ITS_ADDR_W = 7;
  localparam int ITS_SLOTS = 4;
  localparam int ITS_BYTE_W = 8;
  localparam int ITS_FIFO_DEPTH = 32;
  localparam int ITS_DIV_W = 16;
  // bit counts inside a byte
  localparam logic [3:0] ITS_CNT_BYTE = 4'h8;
  localparam logic [3:0] ITS_CNT_LAST_TX = 4'h7;
  // pin synchroniser reset level (bus idle high)
  localparam logic [2:0] ITS_SYNC_RST = 3'h7;

  typedef struct packed {
    logic enable;
    logic qual_extend;
    logic [ITS_ADDR_W-1:0] address0_qualifier;
    logic [ITS_SLOTS-1:0][ITS_ADDR_W-1:0] target_address_field;
    logic [ITS_SLOTS-1:0] address_slot_disable;
  } its_cfg_t;

  typedef struct packed {
    logic software_wait_flag;
    logic not_holding_scl_flag;
    logic target_selected_flag;
    logic deselect_event_flag;
    logic [ITS_BYTE_W-1:0] matched_byte;
  } its_stat_t;

  localparam its_stat_t ITS_STAT_RST = '{
    software_wait_flag: 1'b0,
    not_holding_scl_flag: 1'b1,
    target_selected_flag: 1'b0,
    deselect_event_flag: 1'b0,
    matched_byte: 8'h00
  };

  typedef enum logic [9:0] {
    ITS_IDLE = 10'h001,
    ITS_ADDR = 10'h002,
    ITS_AACK = 10'h004,
    ITS_STRETCH = 10'h008,
    ITS_SETUP = 10'h010,
    ITS_RX = 10'h020,
    ITS_HOLD = 10'h040,
    ITS_RXACK = 10'h080,
    ITS_TX = 10'h100,
    ITS_TXACK = 10'h200
  } its_state_t;

endpackage : its_pkg

// *** design/its_fifo.sv ***
module its_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // pointer wrap only works for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("its_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic do_wr;
  logic do_rd;

  // extra pointer bit tells full from empty
  assign in_ready = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign do_wr = ce && in_valid && in_ready;
  assign do_rd = ce && out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule : its_fifo

// *** testbench/its_master_model.sv ***
module its_master_model #(
  parameter int HALF = 10
) (
  // clock
  input wire logic sys_clk,
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // pulls, high = drive line low
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // target may stretch; bounded so a stuck line ends in the bench timeout
  task automatic up();
    int k;
    k = 0;
    scl_pull <= 1'b0;
    while (scl !== 1'b1 && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    wt(HALF);
  endtask : up
  task automatic start();
    sda_pull <= 1'b0;
    wt(HALF);
    up();
    sda_pull <= 1'b1;
    wt(HALF);
    scl_pull <= 1'b1;
    wt(HALF);
  endtask : start
  task automatic stop();
    sda_pull <= 1'b1;
    wt(HALF);
    up();
    sda_pull <= 1'b0;
    wt(HALF);
  endtask : stop
  // msb first, then the ninth (ack) bit; data only moves while scl low
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] r, output logic ao);
    for (int i = 7; i >= -1; i--) begin
      sda_pull <= (i >= 0) ? ~d[i] : ~a;
      wt(HALF);
      up();
      if (i >= 0) begin
        r[i] = sda;
      end else begin
        ao = sda;
      end
      scl_pull <= 1'b1;
      wt(HALF);
    end
  endtask : xfer
endmodule : its_master_model

// *** testbench/i2c_target_address_status_test.sv ***
module i2c_target_address_status_test import its_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst, ce, sw_continue, deselect_clear, rx_ready, auto_sw;
  logic match_event, rx_valid, scl_oe, sda_oe, m_scl, m_sda, ack, x;
  logic scl_o, sda_o;
  its_cfg_t cfg, base;
  its_stat_t stat;
  logic [15:0] div;
  logic [7:0] tx_byte, rx_data, r;
  logic [6:0] s0, qu, ad;
  logic [3:0] dis;
  logic en, ext, ex;
  int failures, comparisons, cycles, n_match, n;
  logic [7:0] q[$];
  // released lines float to the pull-up level
  wire logic scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda;
  // en ext dis slot0 qual addr expected-ack
  localparam logic [27:0] TB[9] = '{
    {1'b1, 1'b0, 4'h4, 7'h12, 7'h00, 7'h56, 1'b0},
    {1'b0, 1'b0, 4'h0, 7'h12, 7'h00, 7'h34, 1'b0},
    {1'b1, 1'b0, 4'h0, 7'h50, 7'h0F, 7'h5A, 1'b1},
    {1'b1, 1'b0, 4'h0, 7'h50, 7'h0F, 7'h6A, 1'b0},
    {1'b1, 1'b1, 4'h0, 7'h20, 7'h28, 7'h24, 1'b1},
    {1'b1, 1'b1, 4'h0, 7'h20, 7'h28, 7'h28, 1'b1},
    {1'b1, 1'b1, 4'h0, 7'h20, 7'h28, 7'h29, 1'b0},
    {1'b1, 1'b1, 4'h0, 7'h20, 7'h28, 7'h1F, 1'b0},
    {1'b1, 1'b1, 4'h1, 7'h20, 7'h28, 7'h24, 1'b0}};
  initial forever #25 sys_clk = ~sys_clk;
  its_target #(.DIV_W(16), .FIFO_DEPTH(32)) its_target_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .cfg(cfg),
    .bus_clock_divider(div), .sw_continue(sw_continue),
    .tx_byte(tx_byte), .deselect_clear(deselect_clear), .stat(stat),
    .match_event(match_event), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));
  its_master_model #(.HALF(10)) its_master_model_inst (
    .sys_clk(sys_clk), .scl(scl_w), .sda(sda_w),
    .scl_pull(m_scl), .sda_pull(m_sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("counts: %0d compared, %0d bad", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic adr(input logic [6:0] a, input logic rw);
    its_master_model_inst.start();
    its_master_model_inst.xfer({a, rw}, 1'b1, r, x);
    ack = ~x;
  endtask : adr
  task automatic fin();
    its_master_model_inst.stop();
    repeat (8) @(posedge sys_clk);
    deselect_clear <= 1'b1;
    @(posedge sys_clk);
    deselect_clear <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : fin
  // software side and fifo drain; stale pulses outside a stretch are ignored
  always @(posedge sys_clk) begin
    sw_continue <= auto_sw && stat.software_wait_flag && !sw_continue;
    cycles++;
    if (match_event === 1'b1) n_match++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(rx_data, (q.size() > 0) ? q.pop_front() : 8'hXX);
    end
    if (cycles == 60000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    base = '0;
    base.enable = 1'b1;
    base.target_address_field = {7'h78, 7'h56, 7'h34, 7'h12};
    cfg = base;
    // six 50 ns cycles exceed the 250 ns setup
    div = 16'h0005;
    tx_byte = 8'hA5;
    rx_ready = 1'b1;
    auto_sw = 1'b1;
    deselect_clear = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({4'h0, stat[11:8]}, 8'h04);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      adr(base.target_address_field[i], 1'b0);
      check(8'(ack), 8'h01);
      check(stat.matched_byte, {base.target_address_field[i], 1'b0});
      check(8'(stat.target_selected_flag), 8'h01);
      its_master_model_inst.stop();
      repeat (8) @(posedge sys_clk);
      check(8'(stat.deselect_event_flag), 8'h01);
      deselect_clear <= 1'b1;
      @(posedge sys_clk);
      deselect_clear <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(8'(stat.deselect_event_flag), 8'h00);
    end
    check(8'(n_match), 8'h04);
    $display("slot test done");
    for (int i = 0; i < 9; i++) begin
      {en, ext, dis, s0, qu, ad, ex} = TB[i];
      cfg.enable <= en;
      cfg.qual_extend <= ext;
      cfg.address_slot_disable <= dis;
      cfg.target_address_field[0] <= s0;
      cfg.address0_qualifier <= qu;
      repeat (2) @(posedge sys_clk);
      adr(ad, 1'b0);
      check(8'(ack), 8'(ex));
      check(8'(stat.target_selected_flag), 8'(ex));
      fin();
    end
    cfg <= base;
    $display("qualifier test done");
    adr(7'h34, 1'b0);
    check(8'(ack), 8'h01);
    adr(7'h7F, 1'b0);
    check(8'(ack), 8'h00);
    check({4'h0, stat[11:8]}, 8'h05);
    fin();
    $display("repeated start test done");
    auto_sw <= 1'b0;
    rx_ready <= 1'b0;
    adr(7'h78, 1'b0);
    repeat (10) @(posedge sys_clk);
    check({4'h0, stat[11:8]}, 8'h0A);
    check(8'(scl_oe), 8'h01);
    // clock enable low must freeze the stretch despite release pulses
    ce <= 1'b0;
    auto_sw <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check(8'(scl_oe), 8'h01);
    check({4'h0, stat[11:8]}, 8'h0A);
    ce <= 1'b1;
    n = 0;
    while (scl_oe === 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    check(8'(n >= div + 2 && n <= div + 5), 8'h01);
    for (int k = 0; k < 33; k++) q.push_back(8'(k * 7 + 3));
    for (int k = 0; k < 32; k++) begin
      its_master_model_inst.xfer(q[k], 1'b1, r, x);
      check(8'(x), 8'h00);
    end
    fork
      its_master_model_inst.xfer(q[32], 1'b1, r, x);
    join_none
    repeat (400) @(posedge sys_clk);
    // full fifo must hold scl and count as a software wait
    check({3'h0, rx_valid, stat[11:8]}, 8'h1A);
    rx_ready <= 1'b1;
    wait fork;
    check(8'(x), 8'h00);
    fin();
    check(8'(q.size()), 8'h00);
    check(8'(rx_valid), 8'h00);
    $display("stretch and fifo test done");
    adr(7'h12, 1'b1);
    check(stat.matched_byte, 8'h25);
    its_master_model_inst.xfer(8'hFF, 1'b1, r, x);
    check(r, 8'hA5);
    fin();
    $display("read test done");
    stop_test();
  end
endmodule : i2c_target_address_status_test
